// ---- bench/modem_pump_command_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module modem_pump_command_decoder_tb
  import mpcd_pkg::*;
;
  logic clock_in, reset_n_in, cmd_valid, resp_valid, done, hs_report, hs_finished;
  mpcd_cmd_t cmd;
  mpcd_resp_t resp;
  logic [11:0] fe_one, fe_two, mem_addr;
  logic [7:0] hs_status, hs_data;
  logic signed [15:0] tx_sample;
  logic signed [31:0] tx_scaled;
  logic [15:0] ph_one, ph_two, gain;
  logic en_one, en_two, echo_en, eq_en, hs_active, v25_off, hs_start, rt_start, fb_1200, restart;
  int miscompares, checks;

  mpcd_host_model i_host (.clock_in(clock_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  modem_pump_command_decoder i_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .resp_out(resp), .resp_valid_out(resp_valid), .cmd_done_out(done),
    .front_end_reg_one_in(fe_one), .front_end_reg_two_in(fe_two), .hs_report_in(hs_report),
    .hs_status_in(hs_status), .hs_data_in(hs_data), .hs_finished_in(hs_finished),
    .tx_sample_in(tx_sample), .tx_scaled_out(tx_scaled), .tone_one_phase_out(ph_one),
    .tone_two_phase_out(ph_two), .tone_one_enable_out(en_one), .tone_two_enable_out(en_two),
    .echo_adapt_enable_out(echo_en), .equalizer_adapt_enable_out(eq_en),
    .handshake_active_out(hs_active), .v25bis_disable_flag_out(v25_off),
    .handshake_start_out(hs_start), .retrain_start_out(rt_start), .fallback_1200_out(fb_1200),
    .restart_out(restart), .tx_gain_out(gain), .mem_addr_out(mem_addr));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic go(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    i_host.send({op, b1, b2});
    chk("done", 32'h1, done);
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Whole sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clock_in);
    miscompares++;
    wrap_up();
  end

  initial begin
    miscompares = 0;
    checks = 0;
    reset_n_in = 1'b0;
    fe_one = 12'hABC;
    fe_two = 12'h123;
    hs_report = 1'b0;
    hs_finished = 1'b0;
    hs_status = 8'h5A;
    hs_data = 8'h3C;
    tx_sample = 16'sd3;
    repeat (6) @(negedge clock_in);
    reset_n_in = 1'b1;
    chk("adapt", 32'h3, {echo_en, eq_en});
    go(OP_NOP, 8'h00, 8'h00);
    chk("nop", 32'hC, {en_one, en_two, echo_en, eq_en, hs_active, rt_start});
    go(OP_TONE_EN, 8'h03, 8'h00);
    chk("tones", 32'h3, {en_one, en_two});
    go(OP_TONE_ONE, 8'h34, 8'h12);
    chk("phase one", 32'h3_1234, {en_one, en_two, ph_one});
    go(OP_TONE_TWO, 8'h78, 8'h56);
    chk("phase two", 32'h3_5678, {en_one, en_two, ph_two});
    go(OP_TONE_EN, 8'h02, 8'h00);
    chk("tones", 32'h1, {en_one, en_two});
    go(OP_TONE_EN, 8'h00, 8'h00);
    chk("silence", 32'h0, {en_one, en_two});
    go(OP_EQ_FREEZE, 8'h00, 8'h00);
    chk("eq", 32'h0, eq_en);
    go(OP_EQ_RESUME, 8'h00, 8'h00);
    chk("eq", 32'h1, eq_en);
    go(OP_EC_RESUME, 8'h00, 8'h00);
    chk("echo", 32'h1, echo_en);
    go(OP_SET_GAIN, 8'hFE, 8'hFF);
    chk("gain", 32'hFFFE, gain);
    @(negedge clock_in);
    chk("scaled", 32'hFFFF_FFFA, tx_scaled);
    go(OP_FE_READ1, 8'h00, 8'h00);
    chk("read one", 32'h103_BC0A, {resp_valid, resp});
    go(OP_FE_READ2, 8'hFF, 8'hFF);
    chk("read two", 32'h103_2301, {resp_valid, resp});
    go(OP_ADDR_LOAD, 8'h05, 8'h00);
    chk("addr", 32'h5, mem_addr);
    go(OP_STORE_INC, 8'hAA, 8'hBB);
    chk("addr", 32'h6, mem_addr);
    go(OP_STORE_INC, 8'hCC, 8'hDD);
    chk("addr", 32'h7, mem_addr);
    go(OP_ADDR_LOAD, 8'h05, 8'h00);
    chk("word", 32'h103_AABB, {resp_valid, resp});
    go(OP_ADDR_LOAD, 8'h06, 8'h00);
    chk("word", 32'h103_CCDD, {resp_valid, resp});
    go(OP_HANDSHAKE, 8'h00, 8'h01);
    chk("handshake", 32'h7, {hs_start, v25_off, hs_active});
    hs_report = 1'b1;
    @(negedge clock_in);
    chk("report", 32'h15A_3C00, {resp_valid, resp});
    go(OP_FE_READ1, 8'h00, 8'h00);
    hs_report = 1'b0;
    chk("read one", 32'h103_BC0A, {resp_valid, resp});
    @(negedge clock_in);
    chk("held report", 32'h15A_3C00, {resp_valid, resp});
    hs_finished = 1'b1;
    @(negedge clock_in);
    hs_finished = 1'b0;
    go(OP_HANDSHAKE, 8'h00, 8'h00);
    chk("handshake", 32'h5, {hs_start, v25_off, hs_active});
    go(OP_RETRAIN, 8'h00, 8'h01);
    chk("retrain", 32'h3, {rt_start, fb_1200});
    go(OP_RETRAIN, 8'h00, 8'h00);
    chk("retrain", 32'h2, {rt_start, fb_1200});
    go(OP_EC_FREEZE, 8'h00, 8'h00);
    chk("echo", 32'h0, echo_en);
    go(OP_INIT, 8'h00, 8'h00);
    chk("no init", 32'h0_FFFE, {restart, echo_en, gain});
    go(OP_INIT, 8'h00, INIT_BYTE2);
    chk("init", 32'h3_0000, {restart, echo_en, gain});
    chk("init phase", 32'h0, {ph_one, mem_addr});
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- bench/mpcd_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcd_asserts
  import mpcd_pkg::*;
#(
  parameter int AW = ADDR_WIDTH
) (
  // Clock and reset
  input wire logic          clock_in,
  input wire logic          reset_n_in,
  // Command and answer
  input wire logic          cmd_valid_in,
  input wire mpcd_cmd_t     cmd_in,
  input wire mpcd_resp_t    resp_out,
  input wire logic          resp_valid_out,
  input wire logic          cmd_done_out,
  input wire logic [11:0]   front_end_reg_one_in,
  // Controls
  input wire logic [15:0]   tone_one_phase_out,
  input wire logic          tone_one_enable_out,
  input wire logic          tone_two_enable_out,
  input wire logic          echo_adapt_enable_out,
  input wire logic          equalizer_adapt_enable_out,
  input wire logic [15:0]   tx_gain_out,
  input wire logic [AW-1:0] mem_addr_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take(logic [7:0] op);
    cmd_valid_in && cmd_in.opcode == op;
  endsequence
  done_pulse_a: assert property (cmd_valid_in |=> cmd_done_out)
    else $error("command not completed");
  tone_load_a: assert property (s_take(OP_TONE_ONE)
    |=> tone_one_phase_out == $past({cmd_in.byte2, cmd_in.byte1})) else $error("tone one phase");
  tone_keep_a: assert property ((s_take(OP_TONE_ONE) or s_take(OP_TONE_TWO))
    |=> $stable({tone_one_enable_out, tone_two_enable_out})) else $error("tone enable moved");
  tone_silence_a: assert property (s_take(OP_TONE_EN) ##0 cmd_in.byte1[1:0] == 2'b00
    |=> !tone_one_enable_out && !tone_two_enable_out) else $error("tones not silenced");
  echo_freeze_a: assert property (s_take(OP_EC_FREEZE) |=> !echo_adapt_enable_out)
    else $error("echo still adapting");
  eq_resume_a: assert property (s_take(OP_EQ_RESUME) |=> equalizer_adapt_enable_out)
    else $error("equalizer not resumed");
  gain_load_a: assert property (s_take(OP_SET_GAIN)
    |=> tx_gain_out == $past({cmd_in.byte2, cmd_in.byte1})) else $error("gain not loaded");
  store_inc_a: assert property (s_take(OP_STORE_INC)
    |=> mem_addr_out == $past(mem_addr_out) + 1'b1) else $error("address not advanced");
  read_answer_a: assert property (s_take(OP_FE_READ1) |=> resp_valid_out
    && resp_out.byte0[1:0] == 2'b11 && {resp_out.byte2, resp_out.byte1} == {4'h0, $past(front_end_reg_one_in)})
    else $error("front end read answer");
endmodule
bind modem_pump_command_decoder mpcd_asserts #(.AW(AW)) i_asserts (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .resp_out(resp_out), .resp_valid_out(resp_valid_out), .cmd_done_out(cmd_done_out),
  .front_end_reg_one_in(front_end_reg_one_in), .tone_one_phase_out(tone_one_phase_out),
  .tone_one_enable_out(tone_one_enable_out), .tone_two_enable_out(tone_two_enable_out),
  .echo_adapt_enable_out(echo_adapt_enable_out), .equalizer_adapt_enable_out(equalizer_adapt_enable_out),
  .tx_gain_out(tx_gain_out), .mem_addr_out(mem_addr_out));
`default_nettype wire

// ---- bench/mpcd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcd_host_model
  import mpcd_pkg::*;
(
  // Clock
  input  wire logic clock_in,
  // Command to device
  output logic      cmd_valid_out,
  output mpcd_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  // Whole command in one cycle; idle bus inverted so a stale value never looks valid
  task automatic send(input mpcd_cmd_t c);
    @(negedge clock_in);
    cmd_valid_out = 1'b1;
    cmd_out = c;
    @(negedge clock_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~c;
  endtask
endmodule
`default_nettype wire

// ---- core/modem_pump_command_decoder.sv ----
// Overview of operation
// (R1) Host sends three bytes: opcode, then two parameter bytes.
// (R2) Opcode 0E loads tone one phase increment, byte 1 low, byte 2 high.
// (R3) Loading a phase increment never touches the tone enables.
// (R4) Opcode 0F loads tone two phase increment, byte 1 low, byte 2 high.
// (R5) Opcode 16 freezes echo adaptation, 17 resumes it.
// (R6) Opcode 1B freezes equalizer adaptation, 1C resumes it.
// (R7) Command 04 starts handshake; option bit 1 disables V.25bis.
// (R8) During handshake, progress and received bits go to the host.
// (R9) Command 0600C0 restores all defaults and restarts operation.
// (R10) All-zero command completes without any state change.
// (R11) Command 08 reads front end register one, 12 bits, to host.
// (R12) Command 09 reads front end register two, 12 bits, to host.
// (R13) Read answer: low byte, high byte, status with both data bits set.
// (R14) Command 05 starts retrain; byte 2 bit 0 is fallback flag.
// (R15) In V.22bis, fallback 1 selects 1200 bit/s, 0 selects 2400.
// (R16) Opcode 02 stores a 16-bit transmit gain used on every sample.
// (R17) Command 0D0000 disables both tone generators, giving silence.
// (R18) Opcode 13 writes bytes 1 and 2 to the addressed memory word.
// (R19) After the opcode 13 store the memory address increments by one.
// (R20) Opcode 0D bit 0 enables tone one, bit 1 tone two.
// (R21) Opcode 10 loads the memory address and returns its content.
// (R22) Fixed zero parameter bits are ignored unless needed to decode.
`timescale 1ns/1ps
`default_nettype none
module modem_pump_command_decoder
  import mpcd_pkg::*;
#(
  parameter int AW = ADDR_WIDTH
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // Command from host
  input  wire logic        cmd_valid_in,
  input  wire mpcd_cmd_t   cmd_in,
  // Response to host
  output mpcd_resp_t       resp_out,
  output logic             resp_valid_out,
  output logic             cmd_done_out,
  // Analog front end
  input  wire logic [11:0] front_end_reg_one_in,
  input  wire logic [11:0] front_end_reg_two_in,
  // Handshake progress
  input  wire logic        hs_report_in,
  input  wire logic [7:0]  hs_status_in,
  input  wire logic [7:0]  hs_data_in,
  input  wire logic        hs_finished_in,
  // Transmit path
  input  wire logic signed [15:0] tx_sample_in,
  output logic signed [31:0] tx_scaled_out,
  // Control outputs
  output logic [15:0]      tone_one_phase_out,
  output logic [15:0]      tone_two_phase_out,
  output logic             tone_one_enable_out,
  output logic             tone_two_enable_out,
  output logic             echo_adapt_enable_out,
  output logic             equalizer_adapt_enable_out,
  output logic             handshake_active_out,
  output logic             v25bis_disable_flag_out,
  output logic             handshake_start_out,
  output logic             retrain_start_out,
  output logic             fallback_1200_out,
  output logic             restart_out,
  output logic [15:0]      tx_gain_out,
  output logic [AW-1:0]    mem_addr_out
);

  typedef struct packed {
    logic [15:0]       tone_one;
    logic [15:0]       tone_two;
    logic              tone_one_en;
    logic              tone_two_en;
    logic              echo_en;
    logic              eq_en;
    logic              hs_active;
    logic              v25_off;
    logic              hs_start;
    logic              retrain;
    logic              fallback;
    logic              restart;
    logic [15:0]       gain;
    logic [AW-1:0]     addr;
    mpcd_resp_t        resp;
    logic              resp_valid;
    logic              done;
    logic signed [31:0] scaled;
    logic              rep_held;
    mpcd_resp_t        rep_word;
  } mpcd_state_t;

  mpcd_state_t state;
  mpcd_state_t next_state;
  mpcd_kind_t  kind;
  logic [15:0] mem_rdata;
  logic [15:0] param;
  logic        mem_write;
  logic [AW-1:0] mem_addr;
  logic          answer_now;

  function automatic mpcd_resp_t data_resp(input logic [15:0] value);
    mpcd_resp_t r;
    r.byte0 = STATUS_PLAIN;
    r.byte0[DAV_LOW_BIT]  = 1'b1; // (R13)
    r.byte0[DAV_HIGH_BIT] = 1'b1; // (R13)
    r.byte1 = value[7:0];
    r.byte2 = value[15:8];
    return r;
  endfunction

  // Little-endian pairing of the two parameter bytes
  function automatic logic [15:0] word_of(input mpcd_cmd_t c);
    return {c.byte2, c.byte1};
  endfunction

  function automatic logic [AW-1:0] addr_field(input mpcd_cmd_t c);
    logic [15:0] w;
    w = word_of(c);
    return w[AW-1:0];
  endfunction

  // Commands that answer on the response port
  function automatic logic gives_answer(input mpcd_kind_t k);
    logic a;
    case (k)
      CMD_FE1:  a = 1'b1;
      CMD_FE2:  a = 1'b1;
      CMD_ADDR: a = 1'b1;
      default:  a = 1'b0;
    endcase
    return a;
  endfunction

  function automatic mpcd_resp_t report_resp(input logic [7:0] status, input logic [7:0] data);
    mpcd_resp_t r;
    r.byte0 = status;
    r.byte1 = data;
    r.byte2 = 8'h00;
    return r;
  endfunction

  function automatic mpcd_state_t defaults();
    mpcd_state_t s;
    s = '0;
    s.tone_one = PHASE_RESET;
    s.tone_two = PHASE_RESET;
    s.echo_en  = 1'b1;
    s.eq_en    = 1'b1;
    s.gain     = GAIN_RESET;
    // Spelled out so every operating parameter has a stated default
    s.tone_one_en = 1'b0;
    s.tone_two_en = 1'b0;
    s.hs_active   = 1'b0;
    s.v25_off     = 1'b0;
    s.fallback    = 1'b0;
    s.addr        = '0;
    s.rep_held    = 1'b0;
    s.rep_word    = '0;
    return s;
  endfunction

  // Byte 1 low, byte 2 high for every 16-bit parameter
  assign param = word_of(cmd_in);

  mpcd_classify u_classify (
    .cmd_in   (cmd_in),
    .kind_out (kind)
  );

  // Address loads pass straight through so the answer shows the new word
  assign mem_addr  = (cmd_valid_in && kind == CMD_ADDR) ? addr_field(cmd_in) : state.addr;
  assign mem_write = cmd_valid_in && (kind == CMD_STORE);
  // An answering command owns the response port in its cycle
  assign answer_now = cmd_valid_in && gives_answer(kind);

  // No reset on the array; a word read before its first store is unknown
  mpcd_memory #(
    .AW (AW)
  ) u_memory (
    .clock_in  (clock_in),
    .write_in  (mem_write), // (R18)
    .addr_in   (mem_addr),
    .wdata_in  (param),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    next_state = state;
    next_state.hs_start   = 1'b0;
    next_state.retrain    = 1'b0;
    next_state.restart    = 1'b0;
    next_state.resp_valid = 1'b0;
    next_state.done       = 1'b0;
    // Product is registered; one cycle latency on the transmit path
    next_state.scaled = tx_sample_in * $signed(state.gain); // (R16)
    if (hs_finished_in) begin
      next_state.hs_active = 1'b0;
    end
    // A waiting report goes out in the first cycle with neither an answering command nor an init, which discards it
    if (state.rep_held && !answer_now) begin
      next_state.resp       = state.rep_word; // (R8)
      next_state.resp_valid = 1'b1;
      next_state.rep_held   = 1'b0;
    end
    // One slot only: a second clash before it drains keeps the newer report
    if (state.hs_active && hs_report_in) begin
      if (answer_now || state.rep_held) begin
        next_state.rep_held = 1'b1; // (R8)
        next_state.rep_word = report_resp(hs_status_in, hs_data_in); // (R8)
      end else begin
        next_state.resp       = report_resp(hs_status_in, hs_data_in); // (R8)
        next_state.resp_valid = 1'b1;
      end
    end
    // An answering command in the same cycle wins the response port over a report
    if (cmd_valid_in) begin // (R1)
      next_state.done = 1'b1;
      case (kind)
        CMD_GAIN:  next_state.gain = param; // (R16)
        CMD_TONE1: next_state.tone_one = param; // (R2) (R3)
        CMD_TONE2: next_state.tone_two = param; // (R4) (R3)
        CMD_TONE_EN: begin
          // 0D0000 clears both bits and so is silence
          next_state.tone_one_en = cmd_in.byte1[TONE1_BIT]; // (R20) (R17)
          next_state.tone_two_en = cmd_in.byte1[TONE2_BIT]; // (R20) (R17)
        end
        CMD_EC_OFF: next_state.echo_en = 1'b0; // (R5)
        CMD_EC_ON:  next_state.echo_en = 1'b1; // (R5)
        CMD_EQ_OFF: next_state.eq_en = 1'b0; // (R6)
        CMD_EQ_ON:  next_state.eq_en = 1'b1; // (R6)
        CMD_HANDSHAKE: begin
          // Byte 1 zero bits are not checked
          next_state.hs_start  = 1'b1; // (R7) (R22)
          next_state.hs_active = 1'b1; // (R7)
          next_state.v25_off   = cmd_in.byte2[OPTION_BIT]; // (R7)
        end
        CMD_RETRAIN: begin
          next_state.retrain  = 1'b1; // (R14) (R22)
          next_state.fallback = cmd_in.byte2[OPTION_BIT]; // (R14) (R15)
        end
        CMD_INIT: begin
          next_state = defaults(); // (R9)
          next_state.restart = 1'b1; // (R9)
          next_state.done    = 1'b1;
        end
        CMD_FE1: begin
          next_state.resp = data_resp({4'h0, front_end_reg_one_in}); // (R11) (R13)
          next_state.resp_valid = 1'b1;
        end
        CMD_FE2: begin
          next_state.resp = data_resp({4'h0, front_end_reg_two_in}); // (R12) (R13)
          next_state.resp_valid = 1'b1;
        end
        CMD_ADDR: begin
          next_state.addr = addr_field(cmd_in); // (R21)
          next_state.resp = data_resp(mem_rdata); // (R21)
          next_state.resp_valid = 1'b1;
        end
        CMD_STORE: next_state.addr = state.addr + 1'b1; // (R19)
        default: begin
          // Nop and unknown opcodes only complete the exchange
          next_state.done = 1'b1; // (R10)
        end
      endcase
    end
  end

  // Synchronous reset leaves the memory array untouched
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state <= defaults();
    end else begin
      state <= next_state;
    end
  end

  // Answer port
  assign resp_out                   = state.resp;
  assign resp_valid_out             = state.resp_valid;
  assign cmd_done_out               = state.done;

  // Transmit path
  assign tx_scaled_out              = state.scaled;

  // Tone generators
  assign tone_one_phase_out         = state.tone_one;
  assign tone_two_phase_out         = state.tone_two;
  assign tone_one_enable_out        = state.tone_one_en;
  assign tone_two_enable_out        = state.tone_two_en;

  // Adaptation and line control
  assign echo_adapt_enable_out      = state.echo_en;
  assign equalizer_adapt_enable_out = state.eq_en;
  assign handshake_active_out       = state.hs_active;
  assign v25bis_disable_flag_out    = state.v25_off;
  assign handshake_start_out        = state.hs_start;
  assign retrain_start_out          = state.retrain;
  assign fallback_1200_out          = state.fallback;
  assign restart_out                = state.restart;

  // Gain and memory address
  assign tx_gain_out                = state.gain;
  assign mem_addr_out               = state.addr;

endmodule
`default_nettype wire

// ---- core/mpcd_classify.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcd_classify
  import mpcd_pkg::*;
(
  // Command
  input  wire mpcd_cmd_t  cmd_in,
  // Kind
  output mpcd_kind_t      kind_out
);

  always_comb begin
    case (cmd_in.opcode)
      OP_SET_GAIN:  kind_out = CMD_GAIN;
      OP_HANDSHAKE: kind_out = CMD_HANDSHAKE;
      OP_RETRAIN:   kind_out = CMD_RETRAIN;
      // Byte 2 tells init apart from stray opcode 06 words
      OP_INIT:      kind_out = (cmd_in.byte2 == INIT_BYTE2) ? CMD_INIT : CMD_NONE; // (R9)
      OP_FE_READ1:  kind_out = CMD_FE1;
      OP_FE_READ2:  kind_out = CMD_FE2;
      OP_TONE_EN:   kind_out = CMD_TONE_EN;
      OP_TONE_ONE:  kind_out = CMD_TONE1;
      OP_TONE_TWO:  kind_out = CMD_TONE2;
      OP_ADDR_LOAD: kind_out = CMD_ADDR;
      OP_STORE_INC: kind_out = CMD_STORE;
      OP_EC_FREEZE: kind_out = CMD_EC_OFF;
      OP_EC_RESUME: kind_out = CMD_EC_ON;
      OP_EQ_FREEZE: kind_out = CMD_EQ_OFF;
      OP_EQ_RESUME: kind_out = CMD_EQ_ON;
      default:      kind_out = CMD_NONE; // (R10)
    endcase
  end

endmodule
`default_nettype wire

// ---- core/mpcd_memory.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcd_memory
  import mpcd_pkg::*;
#(
  parameter int AW = ADDR_WIDTH
) (
  // Clock
  input  wire logic          clock_in,
  // Access
  input  wire logic          write_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [15:0]   wdata_in,
  output logic      [15:0]   rdata_out
);

  logic [15:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock_in) begin
    if (write_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[addr_in];

endmodule
`default_nettype wire

// ---- core/mpcd_pkg.sv ----
package mpcd_pkg;

  // Opcodes
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_SET_GAIN  = 8'h02;
  localparam logic [7:0] OP_HANDSHAKE = 8'h04;
  localparam logic [7:0] OP_RETRAIN   = 8'h05;
  localparam logic [7:0] OP_INIT      = 8'h06;
  localparam logic [7:0] OP_FE_READ1  = 8'h08;
  localparam logic [7:0] OP_FE_READ2  = 8'h09;
  localparam logic [7:0] OP_TONE_EN   = 8'h0D;
  localparam logic [7:0] OP_TONE_ONE  = 8'h0E;
  localparam logic [7:0] OP_TONE_TWO  = 8'h0F;
  localparam logic [7:0] OP_ADDR_LOAD = 8'h10;
  localparam logic [7:0] OP_STORE_INC = 8'h13;
  localparam logic [7:0] OP_EC_FREEZE = 8'h16;
  localparam logic [7:0] OP_EC_RESUME = 8'h17;
  localparam logic [7:0] OP_EQ_FREEZE = 8'h1B;
  localparam logic [7:0] OP_EQ_RESUME = 8'h1C;
  localparam logic [7:0] INIT_BYTE2   = 8'hC0;

  // Field positions
  localparam int OPTION_BIT = 0;
  localparam int TONE1_BIT  = 0;
  localparam int TONE2_BIT  = 1;
  localparam int DAV_LOW_BIT  = 0;
  localparam int DAV_HIGH_BIT = 1;

  // Widths and reset values
  localparam int FE_WIDTH   = 12;
  localparam int ADDR_WIDTH = 12;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;

  // Response byte 0 status
  localparam logic [7:0] STATUS_PLAIN = 8'h00;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } mpcd_cmd_t;

  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } mpcd_resp_t;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_GAIN      = 4'h1,
    CMD_HANDSHAKE = 4'h2,
    CMD_RETRAIN   = 4'h3,
    CMD_INIT      = 4'h4,
    CMD_FE1       = 4'h5,
    CMD_FE2       = 4'h6,
    CMD_TONE_EN   = 4'h7,
    CMD_TONE1     = 4'h8,
    CMD_TONE2     = 4'h9,
    CMD_ADDR      = 4'hA,
    CMD_STORE     = 4'hB,
    CMD_EC_OFF    = 4'hC,
    CMD_EC_ON     = 4'hD,
    CMD_EQ_OFF    = 4'hE,
    CMD_EQ_ON     = 4'hF
  } mpcd_kind_t;

endpackage
